// ---- pkg/cbs_defines.vh ----
// Purpose: constants for the calibration button sequencer
// Assumes: 100 MHz clk_sys, outputs in mV or uA, position in um
// Notes: counts derive from times in ms and the clock rate in kHz
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH
`define CBS_CLK_KHZ 36'd100000
`define CBS_T_DEB_MS 36'd20
`define CBS_T_UNLOCK_MS 36'd3000
`define CBS_T_GAP_MS 36'd1000
`define CBS_T_SEL_MS 36'd2000
`define CBS_T_EXIT_MS 36'd6000
`define CBS_T_SHORT_MS 36'd1000
`define CBS_T_REP_MS 36'd100
`define CBS_T_IDLE_MS 36'd600000
`define CBS_N_DEB (`CBS_T_DEB_MS * `CBS_CLK_KHZ)
`define CBS_N_UNLOCK (`CBS_T_UNLOCK_MS * `CBS_CLK_KHZ)
`define CBS_N_GAP (`CBS_T_GAP_MS * `CBS_CLK_KHZ)
`define CBS_N_SEL (`CBS_T_SEL_MS * `CBS_CLK_KHZ)
`define CBS_N_EXIT (`CBS_T_EXIT_MS * `CBS_CLK_KHZ)
`define CBS_N_SHORT (`CBS_T_SHORT_MS * `CBS_CLK_KHZ)
`define CBS_N_REP (`CBS_T_REP_MS * `CBS_CLK_KHZ)
`define CBS_N_IDLE (`CBS_T_IDLE_MS * `CBS_CLK_KHZ)
// register byte offsets
`define CBS_A_CTRL 8'h00
`define CBS_A_STATUS 8'h04
`define CBS_A_NULL 8'h08
`define CBS_A_END 8'h0C
`define CBS_A_STRIM 8'h10
`define CBS_A_ETRIM 8'h14
`define CBS_A_OUT 8'h18
// field positions
`define CBS_B_VARIANT 0
`define CBS_B_LOCK 1
`define CBS_B_FACT 2
`define CBS_B_UNL 8
`define CBS_B_BAD 9
// output codes, mV for voltage, uA for current
`define CBS_V_ADJ 16'h07D0
`define CBS_V_TEACH 16'h0FA0
`define CBS_V_ERR 16'h2904
`define CBS_V_ZERO 16'h0000
`define CBS_I_ADJ 16'h1770
`define CBS_I_TEACH 16'h2EE0
`define CBS_I_ERR 16'h0E10
`define CBS_I_ZERO 16'h0FA0
// trim steps and point limits
`define CBS_STEP_FINE 16'h0001
`define CBS_STEP_BIG 16'h000A
`define CBS_MIN_SEP 24'h00_0FA0
`define CBS_FACT_NULL 24'h00_0000
`define CBS_FACT_END 24'h07_A120
`define CBS_RST_CTRL 1'b0
`endif

// ---- src/cbs_debounce.v ----
// Purpose: synchronise and debounce the two button sources
// Assumes: pins are asynchronous to clk_sys
// Notes: a button and its program input are merged after sync
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_debounce #(
  parameter [35:0] N_DEB = `CBS_N_DEB
)(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // raw pins
  input wire btn1_pin,
  input wire btn2_pin,
  input wire program_input_a,
  input wire program_input_b,
  // clean buttons, bit 0 is button one
  output reg [1:0] btn
);
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg [35:0] dcnt_r [0:1];
  wire [1:0] merged;
  integer i;

  // first stage only feeds the second
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else if (ce) begin
      s1_r <= {program_input_b, btn2_pin, program_input_a, btn1_pin};
      s2_r <= s1_r;
    end
  end

  // input a doubles button one, b doubles button two
  assign merged = {s2_r[3] | s2_r[2], s2_r[1] | s2_r[0]};

  // a level must hold for the full window before it counts
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn <= 2'b00;
      for (i = 0; i < 2; i = i + 1) begin
        dcnt_r[i] <= 36'h0;
      end
    end else if (ce) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (merged[i] == btn[i]) begin
          dcnt_r[i] <= 36'h0;
        end else if (dcnt_r[i] >= N_DEB) begin
          btn[i] <= merged[i];
          dcnt_r[i] <= 36'h0;
        end else begin
          dcnt_r[i] <= dcnt_r[i] + 36'h1;
        end
      end
    end
  end
endmodule

// ---- src/cbs_sequencer.v ----
// Purpose: timed button sequence interpreter for calibration
// Assumes: position and scaled_code are on clk_sys, position in um
// Notes: scaled_code comes from the output stage, which applies
//   the points and trims; settings here are held until changed
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_sequencer #(
  parameter [35:0] P_DEB = `CBS_N_DEB,
  parameter [35:0] P_UNLOCK = `CBS_N_UNLOCK,
  parameter [35:0] P_GAP = `CBS_N_GAP,
  parameter [35:0] P_SEL = `CBS_N_SEL,
  parameter [35:0] P_EXIT = `CBS_N_EXIT,
  parameter [35:0] P_SHORT = `CBS_N_SHORT,
  parameter [35:0] P_REP = `CBS_N_REP,
  parameter [35:0] P_IDLE = `CBS_N_IDLE
)(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // buttons and programming lines
  input wire btn1_pin,
  input wire btn2_pin,
  input wire program_input_a,
  input wire program_input_b,
  // measured position
  input wire [23:0] position,
  input wire pos_valid,
  input wire [15:0] scaled_code,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // settings to the output stage
  output reg [15:0] out_code,
  output reg [23:0] null_point,
  output reg [23:0] end_point,
  output reg [15:0] start_trim,
  output reg [15:0] end_trim,
  output reg save_pulse,
  output reg unlocked
);
  localparam [3:0] S_LOCK = 4'h0;
  localparam [3:0] S_ARM1 = 4'h1;
  localparam [3:0] S_GAP = 4'h2;
  localparam [3:0] S_ARMB = 4'h3;
  localparam [3:0] S_UNL = 4'h4;
  localparam [3:0] S_TSEL = 4'h5;
  localparam [3:0] S_ASEL = 4'h6;
  localparam [3:0] S_TEACH = 4'h7;
  localparam [3:0] S_ADJ = 4'h8;
  localparam [3:0] S_TRS = 4'h9;
  localparam [3:0] S_TRE = 4'hA;
  localparam [3:0] S_EXIT = 4'hB;
  localparam [3:0] S_FRST = 4'hC;

  wire [1:0] b;
  reg [1:0] b_prev_r;
  reg [35:0] cnt_r;
  reg [35:0] rep_r;
  reg [3:0] state_r;
  reg [3:0] st_nxt;
  reg armed_r;
  reg go;
  reg cap_null;
  reg cap_end;
  reg step_fine;
  reg step_up;
  reg do_save;
  reg do_fact;
  reg rep_run;
  reg variant_r;
  reg bad_r;
  reg [15:0] out_nxt;
  wire chg;
  wire rep_hit;
  wire rel_single;
  wire acc;
  wire wr;
  wire sw_lock;
  wire sw_fact;
  wire bad_clr;
  wire end_ok;
  wire addr_ok;
  wire [35:0] hold_cnt;

  // true for exactly one button held
  function single;
    input [1:0] c;
    begin
      single = (c == 2'b01) || (c == 2'b10);
    end
  endfunction

  // saturating signed step of a trim value
  function [15:0] trim_step;
    input [15:0] v;
    input [15:0] d;
    input up;
    reg [16:0] s;
    begin
      s = 17'h0_0000;
      if (up) begin
        s = {v[15], v} + {1'b0, d};
      end else begin
        s = {v[15], v} - {1'b0, d};
      end
      if (s[16] != s[15]) begin
        trim_step = s[16] ? 16'h8000 : 16'h7FFF;
      end else begin
        trim_step = s[15:0];
      end
    end
  endfunction

  // identity, error and zero codes per variant
  function [15:0] code_of;
    input cur;
    input [1:0] sel;
    begin
      case ({cur, sel})
        3'b000: code_of = `CBS_V_ADJ;
        3'b001: code_of = `CBS_V_TEACH;
        3'b010: code_of = `CBS_V_ERR;
        3'b011: code_of = `CBS_V_ZERO;
        3'b100: code_of = `CBS_I_ADJ;
        3'b101: code_of = `CBS_I_TEACH;
        3'b110: code_of = `CBS_I_ERR;
        default: code_of = `CBS_I_ZERO;
      endcase
    end
  endfunction

  cbs_debounce #(
    .N_DEB(P_DEB)
  ) u_deb (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .btn1_pin(btn1_pin),
    .btn2_pin(btn2_pin),
    .program_input_a(program_input_a),
    .program_input_b(program_input_b),
    .btn(b)
  );

  // apb decode, zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign addr_ok = (paddr == `CBS_A_CTRL) || (paddr == `CBS_A_STATUS) ||
    (paddr == `CBS_A_NULL) || (paddr == `CBS_A_END) ||
    (paddr == `CBS_A_STRIM) || (paddr == `CBS_A_ETRIM) ||
    (paddr == `CBS_A_OUT);
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign sw_lock = wr && (paddr == `CBS_A_CTRL) && pwdata[`CBS_B_LOCK];
  assign sw_fact = wr && (paddr == `CBS_A_CTRL) && pwdata[`CBS_B_FACT];
  assign bad_clr = wr && (paddr == `CBS_A_STATUS) && pwdata[`CBS_B_BAD];

  // combo change marks the end of the previous combo's duration
  assign chg = (b != b_prev_r);
  assign rel_single = chg && (b == 2'b00) && single(b_prev_r);
  assign rep_hit = (rep_r >= P_REP);
  // the change cycle still carries the old combo's count, so a fresh
  // hold must not inherit a long idle and fire at once
  assign hold_cnt = chg ? 36'h0 : cnt_r;
  // end point above null and far enough away, with a valid position
  assign end_ok = pos_valid && (position > null_point) &&
    (position - null_point >= `CBS_MIN_SEP);

  // sequence decisions
  always @* begin
    st_nxt = state_r;
    go = 1'b0;
    cap_null = 1'b0;
    cap_end = 1'b0;
    step_fine = 1'b0;
    step_up = 1'b0;
    do_save = 1'b0;
    do_fact = 1'b0;
    rep_run = 1'b0;
    case (state_r)
      S_LOCK: begin
        if (single(b) && hold_cnt >= P_UNLOCK) begin
          st_nxt = S_ARM1;
        end
      end
      S_ARM1: begin
        if (b == 2'b00) begin
          st_nxt = S_GAP;
        end else if (b == 2'b11) begin
          st_nxt = S_LOCK;
        end
      end
      S_GAP: begin
        if (b == 2'b11) begin
          st_nxt = S_ARMB;
        end else if (b != 2'b00 || cnt_r >= P_GAP) begin
          st_nxt = S_LOCK;
        end
      end
      S_ARMB: begin
        if (b != 2'b11) begin
          st_nxt = S_LOCK;
        end else if (hold_cnt >= P_UNLOCK) begin
          st_nxt = S_UNL;
        end
      end
      S_UNL: begin
        if (armed_r && b == 2'b01 && hold_cnt >= P_SEL) begin
          st_nxt = S_TSEL;
        end else if (armed_r && b == 2'b10 && hold_cnt >= P_SEL) begin
          st_nxt = S_ASEL;
        end else if (armed_r && b == 2'b11 && hold_cnt >= P_EXIT) begin
          st_nxt = S_FRST;
          do_fact = 1'b1;
        end
      end
      S_TSEL: begin
        if (b == 2'b00) begin
          st_nxt = S_TEACH;
        end
      end
      S_ASEL: begin
        if (b == 2'b00) begin
          st_nxt = S_ADJ;
        end
      end
      S_TEACH: begin
        if (armed_r && b == 2'b01 && hold_cnt >= P_SEL) begin
          cap_null = 1'b1;
          go = 1'b1;
        end else if (armed_r && b == 2'b10 && hold_cnt >= P_SEL) begin
          cap_end = 1'b1;
          go = 1'b1;
        end else if (armed_r && b == 2'b11 && hold_cnt >= P_EXIT) begin
          st_nxt = S_EXIT;
        end
      end
      S_ADJ: begin
        if (armed_r && b == 2'b01 && hold_cnt >= P_SEL) begin
          st_nxt = S_TRS;
        end else if (armed_r && b == 2'b10 && hold_cnt >= P_SEL) begin
          st_nxt = S_TRE;
        end else if (armed_r && b == 2'b11 && hold_cnt >= P_EXIT) begin
          st_nxt = S_EXIT;
        end
      end
      S_TRS, S_TRE: begin
        if (armed_r && chg && b_prev_r == 2'b11) begin
          if (cnt_r <= P_SEL) begin
            do_save = 1'b1;
            st_nxt = S_ADJ;
          end
        end else if (armed_r && rel_single && cnt_r < P_SHORT) begin
          step_fine = 1'b1;
          step_up = (b_prev_r == 2'b01);
        end
        rep_run = armed_r && single(b) && hold_cnt >= P_SHORT;
        if (rep_run && rep_hit) begin
          step_up = (b == 2'b01);
        end
      end
      S_EXIT: begin
        if (armed_r && rel_single && cnt_r < P_SHORT) begin
          st_nxt = S_LOCK;
        end
      end
      S_FRST: begin
        if (b == 2'b00) begin
          st_nxt = S_LOCK;
        end
      end
      default: begin
        st_nxt = S_LOCK;
      end
    endcase
    // idle timeout keeps every setting, only locks
    if (state_r >= S_UNL && b == 2'b00 && hold_cnt >= P_IDLE) begin
      st_nxt = S_LOCK;
    end
    if (sw_lock) begin
      st_nxt = S_LOCK;
    end
    if (sw_fact) begin
      do_fact = 1'b1;
    end
    if (st_nxt != state_r) begin
      go = 1'b1;
    end
  end

  // output code per state
  always @* begin
    out_nxt = scaled_code;
    case (state_r)
      S_UNL, S_EXIT: out_nxt = code_of(variant_r, 2'b10);
      S_TSEL: out_nxt = code_of(variant_r, 2'b01);
      S_ASEL: out_nxt = code_of(variant_r, 2'b00);
      S_FRST: out_nxt = code_of(variant_r, 2'b11);
      S_ADJ: begin
        if (!armed_r) begin
          out_nxt = code_of(variant_r, 2'b00);
        end
      end
      default: out_nxt = scaled_code;
    endcase
    // a rejected point shows error until the next release
    if (bad_r && !armed_r && state_r == S_TEACH) begin
      out_nxt = code_of(variant_r, 2'b10);
    end
  end

  // duration counter saturates so long idles never wrap; the repeat counter clears on each hit
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      b_prev_r <= 2'b00;
      cnt_r <= 36'h0;
      rep_r <= 36'h0;
    end else if (ce) begin
      b_prev_r <= b;
      if (chg) begin
        cnt_r <= 36'h1;
      end else if (cnt_r != {36{1'b1}}) begin
        cnt_r <= cnt_r + 36'h1;
      end
      if (!rep_run || rep_hit) begin
        rep_r <= 36'h0;
      end else begin
        rep_r <= rep_r + 36'h1;
      end
    end
  end

  // state and release tracking
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= S_LOCK;
      armed_r <= 1'b0;
      unlocked <= 1'b0;
      out_code <= 16'h0000;
    end else if (ce) begin
      state_r <= st_nxt;
      // a new hold only counts after all buttons were released
      if (go) begin
        armed_r <= 1'b0;
      end else if (b == 2'b00) begin
        armed_r <= 1'b1;
      end
      unlocked <= (st_nxt >= S_UNL);
      out_code <= out_nxt;
    end
  end

  // calibration settings
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      null_point <= `CBS_FACT_NULL;
      end_point <= `CBS_FACT_END;
      start_trim <= 16'h0000;
      end_trim <= 16'h0000;
      save_pulse <= 1'b0;
      bad_r <= 1'b0;
    end else if (ce) begin
      save_pulse <= do_save | do_fact | (cap_null & pos_valid) |
        (cap_end & end_ok);
      if (do_fact) begin
        null_point <= `CBS_FACT_NULL;
        end_point <= `CBS_FACT_END;
        start_trim <= 16'h0000;
        end_trim <= 16'h0000;
      end else begin
        if (cap_null && pos_valid) begin
          null_point <= position;
        end
        if (cap_end && end_ok) begin
          end_point <= position;
        end
        if ((step_fine || rep_hit && rep_run) && state_r == S_TRS) begin
          start_trim <= trim_step(start_trim, step_fine ?
            `CBS_STEP_FINE : `CBS_STEP_BIG, step_up);
        end
        if ((step_fine || rep_hit && rep_run) && state_r == S_TRE) begin
          end_trim <= trim_step(end_trim, step_fine ?
            `CBS_STEP_FINE : `CBS_STEP_BIG, step_up);
        end
      end
      // set beats a clear in the same cycle
      if ((cap_null && !pos_valid) || (cap_end && !end_ok)) begin
        bad_r <= 1'b1;
      end else if (bad_clr) begin
        bad_r <= 1'b0;
      end
    end
  end

  // config register and registered read data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      variant_r <= `CBS_RST_CTRL;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (wr && paddr == `CBS_A_CTRL) begin
        variant_r <= pwdata[`CBS_B_VARIANT];
      end
      if (psel && !penable) begin
        case (paddr)
          `CBS_A_CTRL: prdata <= {31'h0, variant_r};
          `CBS_A_STATUS: prdata <= {22'h0, bad_r, unlocked, 4'h0,
            state_r};
          `CBS_A_NULL: prdata <= {8'h00, null_point};
          `CBS_A_END: prdata <= {8'h00, end_point};
          `CBS_A_STRIM: prdata <= {16'h0000, start_trim};
          `CBS_A_ETRIM: prdata <= {16'h0000, end_trim};
          `CBS_A_OUT: prdata <= {16'h0000, out_code};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- verification/cbs_sequencer_chk.sv ----
// Purpose: port assertions for the calibration sequencer
// Assumes: ce dropped only while locked, shortened timing parameters
// Notes: bound into cbs_sequencer at the foot of this file
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_seq_chk #(
  parameter [35:0] P_IDLE = 36'd300
)(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // operator lines
  input wire btn1_pin,
  input wire btn2_pin,
  input wire program_input_a,
  input wire program_input_b,
  // position side
  input wire [23:0] position,
  input wire pos_valid,
  input wire [15:0] scaled_code,
  // register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  // results
  input wire [15:0] out_code,
  input wire [23:0] null_point,
  input wire [23:0] end_point,
  input wire save_pulse,
  input wire unlocked
);
  // slack covers synchroniser and debounce lag
  localparam int LIM = int'(P_IDLE) + 20;
  reg [15:0] idle_r;
  wire any_w = btn1_pin | btn2_pin | program_input_a | program_input_b;
  wire acc_w = psel & penable;
  // quiet cycles while in programming mode
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      idle_r <= 16'h0000;
    else if (any_w || !unlocked)
      idle_r <= 16'h0000;
    else if (idle_r != 16'hFFFF)
      idle_r <= idle_r + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_quiet_lock;
    !unlocked && !(acc_w && pwrite) ##1 !unlocked;
  endsequence
  sequence s_settled_lock;
    !$past(rst) && !unlocked && !$past(unlocked) && !$past(unlocked, 2);
  endsequence
  a_pready_high: assert property (acc_w |-> pready)
    else $error("pready low in access phase");
  a_slverr_map: assert property (acc_w && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > 8'h18)) else $error("pslverr wrong");
  a_save_single: assert property (save_pulse |=> !save_pulse)
    else $error("save pulse longer than one cycle");
  a_points_locked: assert property (s_quiet_lock
    |-> $stable(null_point) && $stable(end_point))
    else $error("point moved while locked");
  a_end_order: assert property ($changed(end_point)
    |-> {1'b0, end_point} >= {1'b0, null_point} + 25'h000_0FA0)
    else $error("end point too close or reversed");
  a_null_capture: assert property ($changed(null_point)
    |-> (null_point == $past(position) && $past(pos_valid))
    || (null_point == `CBS_FACT_NULL && end_point == `CBS_FACT_END))
    else $error("null point from bad source");
  a_lock_code: assert property (s_settled_lock
    |-> out_code == $past(scaled_code))
    else $error("locked output not the position");
  a_unlock_err: assert property ($rose(unlocked) |-> ##[0:2]
    (out_code == `CBS_V_ERR || out_code == `CBS_I_ERR))
    else $error("unlock without error code");
  a_idle_lock: assert property (unlocked |-> idle_r <= LIM)
    else $error("idle programming mode not left");
endmodule
bind cbs_sequencer cbs_seq_chk #(.P_IDLE(P_IDLE)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .btn1_pin(btn1_pin),
  .btn2_pin(btn2_pin), .program_input_a(program_input_a),
  .program_input_b(program_input_b), .position(position),
  .pos_valid(pos_valid), .scaled_code(scaled_code), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .out_code(out_code), .null_point(null_point),
  .end_point(end_point), .save_pulse(save_pulse), .unlocked(unlocked));

// ---- verification/cbs_operator.sv ----
// Purpose: operator model pressing buttons or programming lines
// Assumes: bench holds combo and via_prog while busy
// Notes: released lines sit low, pressed lines at supply level
`timescale 1ns/100ps
module cbs_operator (
  // clock
  input wire clk_sys,
  // command
  input wire go,
  input wire [1:0] combo,
  input wire [15:0] dur,
  input wire [15:0] rel,
  input wire via_prog,
  // lines to the device
  output reg btn1_pin,
  output reg btn2_pin,
  output reg program_input_a,
  output reg program_input_b,
  output reg busy
);
  reg [15:0] cnt_r = 16'h0000;
  reg hold_r = 1'b0;
  initial busy = 1'b0;
  // hold for dur cycles, then let go for rel cycles
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      busy <= 1'b1;
      hold_r <= 1'b1;
      cnt_r <= dur;
    end else if (busy && cnt_r > 16'h0001) begin
      cnt_r <= cnt_r - 16'h0001;
    end else if (busy && hold_r) begin
      hold_r <= 1'b0;
      cnt_r <= rel;
    end else begin
      busy <= 1'b0;
    end
  end
  // line a mirrors button one, line b button two, high active
  always @* begin
    btn1_pin = hold_r & combo[0] & !via_prog;
    btn2_pin = hold_r & combo[1] & !via_prog;
    program_input_a = hold_r & combo[0] & via_prog;
    program_input_b = hold_r & combo[1] & via_prog;
  end
endmodule

// ---- verification/cbs_sequencer_bench.sv ----
// Purpose: self-checking bench for the calibration sequencer
// Assumes: shortened timing parameters, ce dropped once while locked
// Notes: expected read data and sampled codes are queued, and a monitor checks the results against them
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_sequencer_bench;
  reg clk_sys, rst, ce, psel, penable, pwrite, pos_valid, chk_oc;
  reg go, via_prog;
  reg [1:0] combo;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [23:0] position, p0;
  reg [15:0] scaled_code, dur, rel;
  wire b1, b2, pa, pb, busy, pready, pslverr, save_pulse, unlocked;
  wire [31:0] prdata;
  wire [15:0] out_code, end_trim;
  wire [23:0] null_point, end_point;
  logic [63:0] exp_q[$];
  integer error_cnt, checks, r;
  localparam [31:0] ALL = 32'hFFFF_FFFF;
  localparam [15:0] NONE = 16'hFFFF;
  // shortened timing, roughly 12 to 20 cycles to the second for the hold and gap times
  localparam [35:0] T_DEB = 36'd4;
  localparam [35:0] T_UNLOCK = 36'd50;
  localparam [35:0] T_GAP = 36'd20;
  localparam [35:0] T_SEL = 36'd30;
  localparam [35:0] T_EXIT = 36'd70;
  localparam [35:0] T_SHORT = 36'd15;
  localparam [35:0] T_REP = 36'd5;
  localparam [35:0] T_IDLE = 36'd300;
  cbs_sequencer #(.P_DEB(T_DEB), .P_UNLOCK(T_UNLOCK), .P_GAP(T_GAP),
    .P_SEL(T_SEL), .P_EXIT(T_EXIT), .P_SHORT(T_SHORT), .P_REP(T_REP),
    .P_IDLE(T_IDLE)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .btn1_pin(b1), .btn2_pin(b2),
    .program_input_a(pa), .program_input_b(pb), .position(position),
    .pos_valid(pos_valid), .scaled_code(scaled_code), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_code(out_code), .null_point(null_point), .end_point(end_point),
    .start_trim(), .end_trim(end_trim), .save_pulse(save_pulse),
    .unlocked(unlocked));
  cbs_operator i_op (.clk_sys(clk_sys), .go(go), .combo(combo),
    .dur(dur), .rel(rel), .via_prog(via_prog), .btn1_pin(b1),
    .btn2_pin(b2), .program_input_a(pa), .program_input_b(pb),
    .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one transfer; reads leave their expectation for the monitor
  task apb(input w, input [7:0] a, input [31:0] d, input [31:0] m);
    integer i;
    if (!w)
      exp_q.push_back({m, d & m});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i = i + 1;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task look_oc(input [15:0] v);
    exp_q.push_back({ALL, 16'h0000, v});
    chk_oc <= 1'b1;
    @(posedge clk_sys);
    chk_oc <= 1'b0;
  endtask
  // press a combo; ov is sampled late in the hold unless NONE
  task press(input [1:0] c, input [15:0] d, input [15:0] rl,
    input [15:0] ov);
    integer i;
    combo <= c;
    dur <= d;
    rel <= rl;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (i = 0; i < 4000 && !(i > 1 && busy === 1'b0); i = i + 1) begin
      @(posedge clk_sys);
      if (i == d - 3 && ov != NONE)
        look_oc(ov);
    end
    if (i >= 4000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  endtask
  task unlock(input [1:0] c, input [15:0] err);
    press(c, 70, 8, NONE);
    press(2'b11, 70, 10, err);
  endtask
  // compare the oldest note with whatever result shows now
  always @(posedge clk_sys) begin
    logic [63:0] e;
    if ((psel && penable && pready && !pwrite) || chk_oc) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 64'hFFFF_FFFF_DEAD_BEEF;
      if (chk_oc)
        check({16'h0000, out_code}, e[31:0]);
      else
        check(prdata & e[63:32], e[31:0]);
    end
  end
  initial begin
    r = $urandom(75445);
    {error_cnt, checks} = 0;
    {rst, ce, pos_valid} = 3'b111;
    {psel, penable, pwrite, go, via_prog, chk_oc, combo} = 0;
    {paddr, pwdata, position, p0} = 0;
    {scaled_code, dur, rel} = {16'h0123, 16'h0001, 16'h0001};
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // reset values, a read-only write and an unmapped place
    apb(1, `CBS_A_NULL, 32'h0000_1234, 0);
    apb(0, `CBS_A_CTRL, 32'h0000_0000, ALL);
    apb(0, `CBS_A_NULL, {8'h00, `CBS_FACT_NULL}, ALL);
    apb(0, `CBS_A_END, {8'h00, `CBS_FACT_END}, ALL);
    apb(0, 8'h1C, 32'h0000_0000, ALL);
    // gap too long: stays locked, then the operator waits it out
    press(2'b01, 70, 30, NONE);
    press(2'b11, 70, 10, NONE);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    repeat (240) @(posedge clk_sys);
    // frozen clock enable: a full single hold must go unseen
    ce <= 1'b0;
    press(2'b01, 70, 8, NONE);
    ce <= 1'b1;
    press(2'b11, 70, 10, NONE);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    repeat (240) @(posedge clk_sys);
    // teach-in on the buttons, voltage codes
    apb(1, `CBS_A_CTRL, 32'h0000_0000, 0);
    unlock(2'b01, `CBS_V_ERR);
    press(2'b01, 45, 10, `CBS_V_TEACH);
    r = $urandom;
    p0 = 24'h01_0000 + {8'h00, r[15:0]};
    position <= p0;
    press(2'b01, 45, 10, NONE);
    apb(0, `CBS_A_NULL, {8'h00, p0}, ALL);
    pos_valid <= 1'b0;
    position <= p0 + 24'h00_0001;
    press(2'b01, 45, 10, NONE);
    apb(0, `CBS_A_NULL, {8'h00, p0}, ALL);
    pos_valid <= 1'b1;
    position <= p0 + 24'h00_0F9F;
    press(2'b10, 45, 10, `CBS_V_ERR);
    apb(0, `CBS_A_STATUS, 32'h0000_0200, 32'h0000_0200);
    apb(0, `CBS_A_END, {8'h00, `CBS_FACT_END}, ALL);
    // sticky bad-point bit clears by writing one
    apb(1, `CBS_A_STATUS, 32'h0000_0200, 0);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0200);
    position <= p0 + 24'h00_0FA0;
    press(2'b10, 45, 10, NONE);
    apb(0, `CBS_A_END, {8'h00, p0 + 24'h00_0FA0}, ALL);
    press(2'b11, 85, 10, `CBS_V_ERR);
    scaled_code <= r[31:16];
    press(2'b01, 8, 10, NONE);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    look_oc(r[31:16]);
    // adjustment on the programming lines, current codes
    apb(1, `CBS_A_CTRL, 32'h0000_0001, 0);
    via_prog <= 1'b1;
    unlock(2'b10, `CBS_I_ERR);
    press(2'b10, 45, 10, `CBS_I_ADJ);
    press(2'b01, 45, 10, NONE);
    repeat (3) press(2'b01, 8, 10, NONE);
    press(2'b10, 8, 10, NONE);
    press(2'b11, 15, 10, NONE);
    apb(0, `CBS_A_STRIM, 32'h0000_0002, 32'h0000_FFFF);
    press(2'b10, 45, 10, NONE);
    press(2'b10, 8, 10, NONE);
    press(2'b01, 30, 10, NONE);
    press(2'b11, 15, 10, NONE);
    check(end_trim > 16'h0008 && end_trim < 16'h0028, 1);
    repeat (400) @(posedge clk_sys);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    apb(0, `CBS_A_STRIM, 32'h0000_0002, 32'h0000_FFFF);
    // factory restore from the buttons
    via_prog <= 1'b0;
    unlock(2'b01, `CBS_I_ERR);
    press(2'b11, 85, 10, `CBS_I_ZERO);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    apb(0, `CBS_A_NULL, {8'h00, `CBS_FACT_NULL}, ALL);
    apb(0, `CBS_A_STRIM, 32'h0000_0000, 32'h0000_FFFF);
    // software lock ends programming, lock bit reads back 0
    unlock(2'b10, `CBS_I_ERR);
    apb(1, `CBS_A_CTRL, 32'h0000_0003, 0);
    apb(0, `CBS_A_STATUS, 32'h0000_0000, 32'h0000_0100);
    apb(0, `CBS_A_CTRL, 32'h0000_0001, ALL);
    close_out;
  end
endmodule
